// File: usb_event_flags.sv
// usb event flag register with mask, interrupt and transfer status fifo
// assumes an AHB-Lite master on hclk, line state and engine events synchronous to hclk
`timescale 1ns/100ps
`include "usb_flag_consts.svh"
module usb_event_flags import usb_flag_pkg::*;
#(
	parameter int IDLE_J_CYCLES = `IDLE_J_CYC,
	parameter int FIFO_DEPTH = 4,
	parameter int STAT_W = 8
)
(
	// system
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// usb line
	input wire logic line_dp,
	input wire logic line_dm,
	input wire logic bus_activity,
	// packet engine events
	input wire logic stall_rx,
	input wire logic stall_tx,
	input wire logic sof_rx,
	input wire logic sof_threshold,
	input wire logic usb_reset_valid,
	input wire logic token_done,
	input wire logic [STAT_W-1:0] token_stat,
	output logic token_ready,
	input wire logic [7:0] err_status,
	// mode and interrupt
	output logic host_mode_enable,
	output logic irq
);
	localparam int PTR_W = $clog2(FIFO_DEPTH);
	localparam int IDLE_W = $clog2(IDLE_J_CYCLES + 1);
	localparam logic [PTR_W:0] FULL = (PTR_W + 1)'(FIFO_DEPTH);
	localparam logic [7:0] RESUME_CYC = 8'(`RESUME_K_CYC);

	typedef struct packed {
		bus_phase_s ph;
		logic [31:0] rdata;
		logic [7:0] flags;
		logic [7:0] flag_en;
		logic host_en;
		logic attach_armed;
		logic [7:0] err_en;
		logic [FIFO_DEPTH-1:0][STAT_W-1:0] mem;
		logic [PTR_W-1:0] rd_ptr;
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W:0] count;
		logic [7:0] k_run;
	} state_s;

	if (FIFO_DEPTH < 2 || (2 ** PTR_W) != FIFO_DEPTH || STAT_W < 1 || STAT_W > 32)
	begin : g_bad
		$error("fifo depth must be a power of two, status width 1 to 32");
	end

	state_s s_reg;
	state_s s_next;
	logic [1:0] line;
	logic line_k;
	logic line_j;
	logic line_se0;
	logic attach_hit;
	logic detach_hit;
	logic resume_hit;
	logic idle_hit;
	logic addr_ok;
	logic wr;
	logic [7:0] clr;
	logic [7:0] set;
	logic push;
	logic pop;
	logic err_live;
	logic [PTR_W:0] count_after;

	assign line = {line_dp, line_dm};
	assign line_k = (line == `LINE_K);
	assign line_j = (line == `LINE_J);
	assign line_se0 = (line == `LINE_SE0);

	// ----------------------------------------------------------------
	// line condition timers
	// ----------------------------------------------------------------
	usb_hold_timer #(.HOLD_CYCLES(`ATTACH_QUIET_CYC), .CNT_W(8)) u_attach
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.cond(s_reg.host_en && !bus_activity && !line_se0),
		.hit(attach_hit)
	);

	usb_hold_timer #(.HOLD_CYCLES(`DETACH_SE0_CYC), .CNT_W(8)) u_detach
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.cond(s_reg.host_en && line_se0),
		.hit(detach_hit)
	);

	usb_hold_timer #(.HOLD_CYCLES(`RESUME_K_CYC), .CNT_W(8)) u_resume
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.cond(line_k),
		.hit(resume_hit)
	);

	usb_hold_timer #(.HOLD_CYCLES(IDLE_J_CYCLES), .CNT_W(IDLE_W)) u_idle
	(
		.hclk(hclk),
		.hresetn(hresetn),
		.cond(line_j && !bus_activity),
		.hit(idle_hit)
	);

	// ----------------------------------------------------------------
	// event, bus and fifo logic
	// ----------------------------------------------------------------
	assign addr_ok = hsel && hready && htrans[1];
	assign wr = s_reg.ph.act && s_reg.ph.write;
	assign err_live = |(err_status & s_reg.err_en);
	assign push = token_done && (s_reg.count != FULL);
	assign count_after = s_reg.count - (PTR_W + 1)'(pop) + (PTR_W + 1)'(push);

	always_comb
	begin
		s_next = s_reg;
		clr = '0;
		if (wr && s_reg.ph.ofs == `OFS_FLAGS)
		begin
			clr = hwdata[7:0] & `FLAG_W1C_MASK;
		end
		pop = clr[`FLAG_TOKEN] && s_reg.flags[`FLAG_TOKEN] && (s_reg.count != '0);
		set = '0;
		set[`FLAG_STALL] = s_reg.host_en ? stall_rx : stall_tx;
		set[`FLAG_ATTACH] = attach_hit && s_reg.attach_armed;
		set[`FLAG_RESUME] = resume_hit;
		set[`FLAG_IDLE] = idle_hit;
		// a further entry waiting behind the popped one raises the flag again
		set[`FLAG_TOKEN] = push || (pop && count_after != '0);
		set[`FLAG_SOF] = s_reg.host_en ? sof_threshold : sof_rx;
		set[`FLAG_RSTDET] = s_reg.host_en ? detach_hit : usb_reset_valid;
		s_next.flags = (s_reg.flags & ~clr) | set;
		s_next.flags[`FLAG_ERR] = err_live;
		if (detach_hit || (set[`FLAG_ATTACH]))
		begin
			s_next.attach_armed = detach_hit;
		end
		if (wr && s_reg.ph.ofs == `OFS_FLAG_EN)
		begin
			s_next.flag_en = hwdata[7:0];
		end
		else if (wr && s_reg.ph.ofs == `OFS_CTRL)
		begin
			s_next.host_en = hwdata[`CTRL_HOST_BIT];
			// entering host mode looks for a first attach
			if (hwdata[`CTRL_HOST_BIT] && !s_reg.host_en)
			begin
				s_next.attach_armed = 1'b1;
			end
		end
		else if (wr && s_reg.ph.ofs == `OFS_ERR_EN)
		begin
			s_next.err_en = hwdata[7:0];
		end
		if (push)
		begin
			s_next.mem[s_reg.wr_ptr] = token_stat;
			s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
		end
		if (pop)
		begin
			s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
		end
		s_next.count = count_after;
		s_next.k_run = !line_k ? 8'h00 : (s_reg.k_run == RESUME_CYC ? s_reg.k_run :
			s_reg.k_run + 8'h01);
		s_next.ph.act = addr_ok;
		s_next.ph.write = hwrite;
		s_next.ph.ofs = haddr[7:0];
		// read data is latched in the address phase, so reads have no wait state
		s_next.rdata = `WORD_ZERO;
		if (addr_ok && !hwrite)
		begin
			if (haddr[7:0] == `OFS_FLAGS)
			begin
				s_next.rdata = {`UPPER_ZERO, s_reg.flags};
			end
			else if (haddr[7:0] == `OFS_FLAG_EN)
			begin
				s_next.rdata = {`UPPER_ZERO, s_reg.flag_en};
			end
			else if (haddr[7:0] == `OFS_CTRL)
			begin
				s_next.rdata = {31'h0000_0000, s_reg.host_en};
			end
			else if (haddr[7:0] == `OFS_ERR_EN)
			begin
				s_next.rdata = {`UPPER_ZERO, s_reg.err_en};
			end
			else if (haddr[7:0] == `OFS_XFER_STAT && s_reg.count != '0)
			begin
				s_next.rdata = 32'(s_reg.mem[s_reg.rd_ptr]);
			end
			else if (haddr[7:0] == `OFS_FIFO_LVL)
			begin
				s_next.rdata = 32'(s_reg.count);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_reg <= '0;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_reg.rdata;
	assign token_ready = (s_reg.count != FULL);
	assign host_mode_enable = s_reg.host_en;
	assign irq = |(s_reg.flags & s_reg.flag_en);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	logic rd_flags;
	logic w1_stall;
	logic w0_stall;
	logic en_stall_wr;
	logic host_now;
	logic se0_now;
	assign rd_flags = addr_ok && !hwrite && haddr[7:0] == `OFS_FLAGS;
	assign w1_stall = clr[`FLAG_STALL] && !set[`FLAG_STALL];
	assign w0_stall = wr && s_reg.ph.ofs == `OFS_FLAGS && !hwdata[`FLAG_STALL];
	assign en_stall_wr = wr && s_reg.ph.ofs == `OFS_FLAG_EN && hwdata[`FLAG_STALL];
	assign host_now = s_reg.host_en;
	assign se0_now = line_se0;

	property p_upper_zero;
		rd_flags |=> hrdata[31:8] == `UPPER_ZERO;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("flag upper bits not zero");

	property p_w1c;
		w1_stall |=> !s_reg.flags[`FLAG_STALL];
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

	property p_w0_keep;
		(w0_stall && s_reg.flags[`FLAG_STALL]) |=> s_reg.flags[`FLAG_STALL];
	endproperty
	a_w0_keep: assert property (p_w0_keep) else $error("write zero changed flag");

	property p_set_wins;
		(|set) |=> ((s_reg.flags & $past(set)) == $past(set));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("set event lost");

	property p_stall_host;
		(s_reg.host_en && stall_rx) |=> s_reg.flags[`FLAG_STALL];
	endproperty
	a_stall_host: assert property (p_stall_host) else $error("host stall not flagged");

	property p_attach_qual;
		$rose(s_reg.flags[`FLAG_ATTACH]) |-> $past(host_now) && !$past(se0_now);
	endproperty
	a_attach_qual: assert property (p_attach_qual) else $error("attach without qualify");

	property p_resume_time;
		$rose(s_reg.flags[`FLAG_RESUME]) |-> $past(s_reg.k_run) == RESUME_CYC;
	endproperty
	a_resume_time: assert property (p_resume_time) else $error("resume flag too early");

	property p_token_push;
		push |=> s_reg.flags[`FLAG_TOKEN] && s_reg.count != '0;
	endproperty
	a_token_push: assert property (p_token_push) else $error("token done not shown");

	property p_fifo_adv;
		(pop && !push) |=> s_reg.count == $past(s_reg.count) - 1'b1;
	endproperty
	a_fifo_adv: assert property (p_fifo_adv) else $error("fifo did not advance");

	property p_err_sum;
		##1 s_reg.flags[`FLAG_ERR] == $past(err_live);
	endproperty
	a_err_sum: assert property (p_err_sum) else $error("error summary wrong");

	property p_bit0_dev;
		(!s_reg.host_en && usb_reset_valid) |=> s_reg.flags[`FLAG_RSTDET];
	endproperty
	a_bit0_dev: assert property (p_bit0_dev) else $error("bus reset not flagged");

	property p_bit0_host;
		(s_reg.host_en && detach_hit) |=> s_reg.flags[`FLAG_RSTDET];
	endproperty
	a_bit0_host: assert property (p_bit0_host) else $error("detach not flagged");

	property p_irq;
		(en_stall_wr && s_reg.flags[`FLAG_STALL]) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("enabled flag gave no interrupt");

	c_token_pop: cover property (push ##[1:20] pop);
	c_resume: cover property ($rose(s_reg.flags[`FLAG_RESUME]));
	c_irq: cover property ($rose(irq));
	c_attach: cover property ($rose(s_reg.flags[`FLAG_ATTACH]));

endmodule

// File: usb_flag_consts.svh
// constants for the usb event flag block: offsets, bit positions, reset values, timing
// assumes a 40 MHz system clock on hclk; included by its bare name
`ifndef USB_FLAG_CONSTS_SVH
`define USB_FLAG_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, low address byte decoded)
// ----------------------------------------------------------------
`define OFS_FLAGS 8'h00
`define OFS_FLAG_EN 8'h04
`define OFS_CTRL 8'h08
`define OFS_ERR_EN 8'h0C
`define OFS_XFER_STAT 8'h10
`define OFS_FIFO_LVL 8'h14

// ----------------------------------------------------------------
// flag bit positions and masks
// ----------------------------------------------------------------
`define FLAG_STALL 7
`define FLAG_ATTACH 6
`define FLAG_RESUME 5
`define FLAG_IDLE 4
`define FLAG_TOKEN 3
`define FLAG_SOF 2
`define FLAG_ERR 1
`define FLAG_RSTDET 0
`define FLAG_W1C_MASK 8'hFD
`define CTRL_HOST_BIT 0
`define FLAGS_RST 8'h00
`define EN_RST 8'h00
`define WORD_ZERO 32'h0000_0000
`define UPPER_ZERO 24'h00_0000

// ----------------------------------------------------------------
// line states as {dp, dm}, full speed
// ----------------------------------------------------------------
`define LINE_SE0 2'b00
`define LINE_J 2'b10
`define LINE_K 2'b01

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define RESUME_K_NS 2500
`define ATTACH_QUIET_NS 2500
`define DETACH_SE0_NS 2500
`define IDLE_J_MS 3
`define RESUME_K_CYC ((`RESUME_K_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ATTACH_QUIET_CYC ((`ATTACH_QUIET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DETACH_SE0_CYC ((`DETACH_SE0_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IDLE_J_CYC ((`IDLE_J_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: usb_flag_pkg.sv
// types shared by the usb event flag block
// assumes nothing beyond a SystemVerilog compiler
package usb_flag_pkg;

	// ----------------------------------------------------------------
	// bus and timer types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		HT_IDLE = 2'b00,
		HT_BUSY = 2'b01,
		HT_NONSEQ = 2'b10,
		HT_SEQ = 2'b11
	} htrans_e;

	typedef enum logic [1:0] {
		HOLD_WAIT = 2'b01,
		HOLD_DONE = 2'b10
	} hold_state_e;

	typedef struct packed {
		logic act;
		logic write;
		logic [7:0] ofs;
	} bus_phase_s;

endpackage

// File: usb_hold_timer.sv
// hold timer: pulses once when a condition has stood for a set number of cycles
// assumes cond is synchronous to hclk
`timescale 1ns/100ps
module usb_hold_timer import usb_flag_pkg::*;
#(
	parameter int HOLD_CYCLES = 100,
	parameter int CNT_W = 17
)
(
	// system
	input wire logic hclk,
	input wire logic hresetn,
	// condition and result
	input wire logic cond,
	output logic hit
);
	typedef struct packed {
		hold_state_e st;
		logic [CNT_W-1:0] cnt;
		logic hit;
	} hold_s;

	localparam logic [CNT_W-1:0] LAST = CNT_W'(HOLD_CYCLES - 1);

	hold_s s_reg;
	hold_s s_next;

	if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (2 ** CNT_W))
	begin : g_bad
		$error("hold count does not fit the counter");
	end

	// ----------------------------------------------------------------
	// counting
	// ----------------------------------------------------------------
	// once done the timer waits for cond to drop, so one hold gives one pulse
	always_comb
	begin
		s_next = s_reg;
		s_next.hit = 1'b0;
		if (!cond)
		begin
			s_next.st = HOLD_WAIT;
			s_next.cnt = '0;
		end
		else
		begin
			case (s_reg.st)
				HOLD_WAIT:
				begin
					if (s_reg.cnt == LAST)
					begin
						s_next.st = HOLD_DONE;
						s_next.hit = 1'b1;
					end
					else
					begin
						s_next.cnt = s_reg.cnt + 1'b1;
					end
				end
				HOLD_DONE:
				begin
					s_next.st = HOLD_DONE;
				end
				default:
				begin
					s_next.st = HOLD_WAIT;
					s_next.cnt = '0;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_reg <= '{st: HOLD_WAIT, cnt: '0, hit: 1'b0};
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign hit = s_reg.hit;

endmodule

// File: usb_line_model.sv
// far-side model of the usb line: drives the two data lines and the activity flag
// assumes mode is changed by the bench just after a rising edge of hclk
`timescale 1ns/100ps
`include "usb_flag_consts.svh"
module usb_line_model import usb_flag_pkg::*;
(
	// system
	input wire logic hclk,
	input wire logic hresetn,
	// requested behaviour: 0 idle J, 1 held K, 2 SE0, 3 traffic
	input wire logic [1:0] mode,
	// line
	output logic line_dp,
	output logic line_dm,
	output logic bus_activity
);
	logic tog;

	// ----------------------------------------------------------------
	// traffic toggles J and K every cycle, so no timer ever completes
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tog <= 1'b0;
		else
			tog <= !tog;
	end

	always_comb
	begin
		case (mode)
			2'h0: {line_dp, line_dm} = `LINE_J;
			2'h1: {line_dp, line_dm} = `LINE_K;
			2'h2: {line_dp, line_dm} = `LINE_SE0;
			default: {line_dp, line_dm} = tog ? `LINE_J : `LINE_K;
		endcase
		bus_activity = (mode == 2'h3);
	end
endmodule

// File: test_usb_event_flags.sv
// self-checking bench for the usb event flag register
// assumes the flag block, the line model and the constants header are compiled first
`timescale 1ns/100ps
`include "usb_flag_consts.svh"
module test_usb_event_flags import usb_flag_pkg::*;
;
	typedef struct packed {logic host; logic [4:0] ev; logic [7:0] flags;} row_s;
	localparam int IDLE_N = 50;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic token_done, token_ready, host_mode_enable, line_dp, line_dm, bus_activity;
	logic [31:0] haddr, hwdata, hrdata, rd_q;
	logic [1:0] htrans, line_mode;
	logic [4:0] ev_vec;
	logic [7:0] token_stat, err_status;
	int err_count, n_checks;
	// ev bits: stall_rx, stall_tx, sof_rx, sof_threshold, usb_reset_valid
	row_s rows [9] = '{'{1'b0, 5'h08, 8'h80}, '{1'b1, 5'h10, 8'h80}, '{1'b0, 5'h10, 8'h00},
		'{1'b1, 5'h08, 8'h00}, '{1'b0, 5'h04, 8'h04}, '{1'b1, 5'h02, 8'h04},
		'{1'b1, 5'h04, 8'h00}, '{1'b0, 5'h01, 8'h01}, '{1'b1, 5'h01, 8'h00}};

	usb_event_flags #(.IDLE_J_CYCLES(IDLE_N)) i_usb_event_flags (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .line_dp(line_dp), .line_dm(line_dm),
		.bus_activity(bus_activity), .stall_rx(ev_vec[4]), .stall_tx(ev_vec[3]),
		.sof_rx(ev_vec[2]), .sof_threshold(ev_vec[1]), .usb_reset_valid(ev_vec[0]),
		.token_done(token_done), .token_stat(token_stat), .token_ready(token_ready),
		.err_status(err_status), .host_mode_enable(host_mode_enable), .irq(irq));
	usb_line_model i_usb_line_model (.hclk(hclk), .hresetn(hresetn), .mode(line_mode),
		.line_dp(line_dp), .line_dm(line_dm), .bus_activity(bus_activity));

	initial
	begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic wrap_up();
		if (err_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_bit(input string nm, input logic e, input logic g);
		chk_word(nm, {31'h0000_0000, e}, {31'h0000_0000, g});
	endtask

	// outputs read right after the edge still hold the value that this edge sampled,
	// so a register written at an edge is checked one edge later
	task automatic tick();
		@(posedge hclk);
	endtask

	task automatic wait_rdy();
		int n;
		n = 0;
		do
		begin
			tick();
			n++;
		end
		while (hreadyout !== 1'b1 && n < 16);
		if (hreadyout !== 1'b1)
		begin
			err_count++;
			wrap_up();
		end
	endtask

	// one single transfer; ev pulses engine events during the data phase
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [4:0] ev);
		hsel <= 1'b1;
		htrans <= HT_NONSEQ;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= HT_IDLE;
		hwdata <= d;
		ev_vec <= ev;
		wait_rdy();
		rd_q = hrdata;
		// only a pulse that was raised is lowered, so a caller may drive ev_vec here
		if (ev != 5'h00)
			ev_vec <= 5'h00;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d, 5'h00);
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0000_0000, 5'h00);
		chk_word(nm, e, rd_q);
	endtask

	// hold a line state for n cycles, then return to traffic
	task automatic line_run(input logic [1:0] m, input int n);
		line_mode <= m;
		repeat (n) tick();
		line_mode <= 2'h3;
		tick();
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{hresetn, hsel, hwrite, token_done} = 4'h0;
		{haddr, hwdata} = 64'h0000_0000_0000_0000;
		{htrans, ev_vec, token_stat, err_status} = 23'h00_0000;
		line_mode = 2'h3;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		for (int a = 0; a < 7; a++)
			rd_chk("reset reg", 8'(a * 4), 32'h0000_0000);
		chk_bit("irq reset", 1'b0, irq);
		chk_bit("hresp", 1'b0, hresp);
		chk_bit("host reset", 1'b0, host_mode_enable);
		wr(`OFS_FLAG_EN, 32'h0000_00DF);
		rd_chk("mask", `OFS_FLAG_EN, 32'h0000_00DF);
		foreach (rows[i])
		begin
			wr(`OFS_CTRL, {31'h0000_0000, rows[i].host});
			ev_vec <= rows[i].ev;
			tick();
			ev_vec <= 5'h00;
			chk_bit("host", rows[i].host, host_mode_enable);
			tick();
			rd_chk("flags", `OFS_FLAGS, {24'h00_0000, rows[i].flags});
			chk_bit("irq", |(rows[i].flags & 8'hDF), irq);
			wr(`OFS_FLAGS, 32'hFFFF_FFFF);
			rd_chk("cleared", `OFS_FLAGS, 32'h0000_0000);
		end
		// line timers, device mode first
		wr(`OFS_CTRL, 32'h0000_0000);
		line_run(2'h1, 95);
		rd_chk("resume early", `OFS_FLAGS, 32'h0000_0000);
		line_run(2'h1, 105);
		rd_chk("resume", `OFS_FLAGS, 32'h0000_0020);
		line_run(2'h0, IDLE_N - 5);
		rd_chk("idle early", `OFS_FLAGS, 32'h0000_0020);
		line_run(2'h0, 105);
		rd_chk("idle", `OFS_FLAGS, 32'h0000_0030);
		wr(`OFS_FLAGS, 32'h0000_00FF);
		wr(`OFS_CTRL, 32'h0000_0001);
		line_run(2'h2, 105);
		rd_chk("detach", `OFS_FLAGS, 32'h0000_0001);
		wr(`OFS_FLAGS, 32'h0000_0001);
		line_run(2'h0, 105);
		rd_chk("attach", `OFS_FLAGS, 32'h0000_0050);
		chk_bit("irq set", 1'b1, irq);
		wr(`OFS_FLAG_EN, 32'h0000_0000);
		tick();
		chk_bit("irq masked", 1'b0, irq);
		wr(`OFS_FLAGS, 32'h0000_00FF);
		wr(`OFS_CTRL, 32'h0000_0000);
		// error summary follows only enabled errors and ignores writes
		err_status <= 8'h10;
		repeat (2) tick();
		rd_chk("err off", `OFS_FLAGS, 32'h0000_0000);
		wr(`OFS_ERR_EN, 32'h0000_0010);
		rd_chk("err en", `OFS_ERR_EN, 32'h0000_0010);
		rd_chk("err on", `OFS_FLAGS, 32'h0000_0002);
		wr(`OFS_FLAGS, 32'h0000_0002);
		rd_chk("err ro", `OFS_FLAGS, 32'h0000_0002);
		err_status <= 8'h01;
		repeat (2) tick();
		rd_chk("err other", `OFS_FLAGS, 32'h0000_0000);
		// two tokens back to back, then pop them one by one
		chk_bit("room", 1'b1, token_ready);
		token_done <= 1'b1;
		token_stat <= 8'hA5;
		tick();
		token_stat <= 8'h3C;
		tick();
		token_done <= 1'b0;
		tick();
		rd_chk("token", `OFS_FLAGS, 32'h0000_0008);
		rd_chk("stat", `OFS_XFER_STAT, 32'h0000_00A5);
		rd_chk("level", `OFS_FIFO_LVL, 32'h0000_0002);
		wr(`OFS_FLAGS, 32'h0000_0008);
		tick();
		rd_chk("token again", `OFS_FLAGS, 32'h0000_0008);
		rd_chk("stat next", `OFS_XFER_STAT, 32'h0000_003C);
		wr(`OFS_FLAGS, 32'h0000_0008);
		tick();
		rd_chk("token gone", `OFS_FLAGS, 32'h0000_0000);
		rd_chk("level empty", `OFS_FIFO_LVL, 32'h0000_0000);
		// stall sent in the very cycle its clear lands
		ahb(1'b1, `OFS_FLAGS, 32'h0000_0080, 5'h08);
		rd_chk("set wins", `OFS_FLAGS, 32'h0000_0080);
		// four entries fill the fifo, the fifth token is refused
		token_done <= 1'b1;
		token_stat <= 8'h5A;
		repeat (5) tick();
		token_done <= 1'b0;
		chk_bit("full", 1'b0, token_ready);
		rd_chk("level full", `OFS_FIFO_LVL, 32'h0000_0004);
		// reset in mid-run clears everything; resume stays masked by the DF enable value
		wr(`OFS_FLAG_EN, 32'h0000_00DF);
		tick();
		chk_bit("irq live", 1'b1, irq);
		hresetn <= 1'b0;
		repeat (2) tick();
		hresetn <= 1'b1;
		tick();
		chk_bit("irq after reset", 1'b0, irq);
		chk_bit("room after reset", 1'b1, token_ready);
		rd_chk("flags after reset", `OFS_FLAGS, 32'h0000_0000);
		rd_chk("en after reset", `OFS_FLAG_EN, 32'h0000_0000);
		rd_chk("level after reset", `OFS_FIFO_LVL, 32'h0000_0000);
		wrap_up();
	end
endmodule
